// [core/qph_pkg.sv]
// Functional notes
// - four channels numbered one to four; a group select picks the target channel.
// - each channel keeps an 8-bit direction mask, 1 means output, 0 input.
// - an output value write loads only the selected channel's output register.
// - data reads return present line levels, 0 to 255, idle lines read 255.
// - reset or defaults restore clears every direction mask, all lines become inputs.
// - defaults: deferred trigger mode off and channel one selected.
// - defaults for channels two to four: action none, edge polarity negative.
// - defaults restore returns all settings and never raises a service request.
// - handshake clear resets the handshake line state, settings stay unchanged.
// - action both: selected channel strobe edge raises condition and service request.
// - action condition: strobe edge raises wait condition only.
// - action request: strobe edge raises service request only.
// - action none: strobe edges raise nothing.
// - channel one has no strobes, no edge logic, action or flag.
// - each handshake channel detects positive or negative edges per its polarity.
// - each handshake channel keeps a readable occurrence flag of strobe events.
// - deferred mode with bus trigger holds settings until the bus trigger.
// - deferred mode with command trigger holds settings until the fire command.
// - deferred mode off applies at once and ignores both trigger sources.
// - activity indicator lights each time the host selects the card.
// - self-test fault keeps the error indicator lit and is reported.
// - action, polarity and flag accesses fail with error 204 on channel one.
// - reading the occurrence flag clears it until a new strobe event.
// - each card selection keeps the activity indicator lit at least 20 ms.
package qph_pkg;

  localparam int NCH = 4;
  localparam int NHS = 3;
  localparam int DW  = 8;
  localparam int AW  = 8;

  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_CMD    = 8'h04;
  localparam logic [AW-1:0] OFS_DIR    = 8'h08;
  localparam logic [AW-1:0] OFS_OUTVAL = 8'h0C;
  localparam logic [AW-1:0] OFS_PINS   = 8'h10;
  localparam logic [AW-1:0] OFS_ARM    = 8'h14;
  localparam logic [AW-1:0] OFS_FLAG   = 8'h18;
  localparam logic [AW-1:0] OFS_STATUS = 8'h1C;

  // control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_DT_LSB  = 2;
  // command register bits
  localparam int CMD_RESTORE = 0;
  localparam int CMD_HSCLR   = 1;
  localparam int CMD_FIRE    = 2;
  // arm register fields
  localparam int ARM_ACT_LSB = 0;
  localparam int ARM_POL_BIT = 2;
  localparam int ACT_WAIT_SATISFIER    = 0;
  localparam int ACT_SRQ     = 1;
  // status register fields
  localparam int ST_SRQ     = 0;
  localparam int ST_WAIT_SATISFIER    = 1;
  localparam int ST_FAULT   = 2;
  localparam int ST_PEND    = 3;
  localparam int ST_ERR_LSB = 8;

  typedef enum logic [1:0] {
    DT_OFF = 2'h0,
    DT_BUS = 2'h1,
    DT_CMD = 2'h2
  } qph_dt_t;

  localparam logic [1:0]    ACTION_NONE = 2'h0;
  localparam logic          POL_NEG     = 1'h0;
  localparam logic [1:0]    SEL_CH1     = 2'h0;
  localparam logic [DW-1:0] DIR_RESET   = 8'h00;
  localparam logic [DW-1:0] OUT_RESET   = 8'h00;
  localparam logic [DW-1:0] ERR_NONE    = 8'h00;
  localparam logic [DW-1:0] ERR_CH1     = 8'hCC;

  // activity indicator hold time
  localparam int ACT_HOLD_MS = 20;
  localparam int CLK_KHZ     = 200000;
  localparam logic [22:0] ACT_HOLD_CYC = 23'(ACT_HOLD_MS * CLK_KHZ);

  // self-test fault sampled once the synchroniser has filled
  localparam logic [1:0] BOOT_SAMPLE = 2'h2;
  localparam logic [1:0] BOOT_DONE   = 2'h3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } qph_bus_t;

endpackage

// [core/qph_hs_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module qph_hs_edge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic output_taken_strobe,
  input  wire logic input_valid_strobe,
  input  wire logic pos_edge,
  input  wire logic rearm,
  output logic      evt
);
  import qph_pkg::*;

  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] h_q;
  logic [1:0] hit;
  logic       evt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // synchroniser starts at the idle-high strobe level
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end else if (ce) begin
      s1_q <= {input_valid_strobe, output_taken_strobe};
      s2_q <= s1_q;
    end
  end

  // history starts high so an idle-high strobe gives no edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h_q <= 2'h3;
    end else if (ce) begin
      h_q <= s2_q;
    end
  end

  assign hit = pos_edge ? (s2_q & ~h_q) : (~s2_q & h_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= 1'h0;
    end else if (ce) begin
      evt_q <= (|hit) & ~rearm;
    end
  end

  assign evt = evt_q;
endmodule
`default_nettype wire

// [core/qph_io_top.sv]
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module qph_io_top #(
  parameter logic [22:0] ACT_HOLD_CYCLES = qph_pkg::ACT_HOLD_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [qph_pkg::AW-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire logic [qph_pkg::NCH-1:0][qph_pkg::DW-1:0] pio_in,
  output logic [qph_pkg::NCH-1:0][qph_pkg::DW-1:0]      pio_out,
  output logic [qph_pkg::NCH-1:0][qph_pkg::DW-1:0]      pio_oe,
  input  wire logic [qph_pkg::NHS-1:0] output_taken_strobe,
  input  wire logic [qph_pkg::NHS-1:0] input_valid_strobe,
  input  wire logic                    bus_trigger,
  input  wire logic                    card_selected,
  input  wire logic                    self_test_fault,
  output logic                         srq,
  output logic                         wait_satisfier,
  output logic                         activity_led,
  output logic                         error_led,
  output logic                         pending
);
  import qph_pkg::*;

  // handshake array index of a channel select code (channel 2 -> 0)
  function automatic logic [1:0] hs_idx(input logic [1:0] sel);
    hs_idx = sel - 2'h1;
  endfunction

  // accesses that only exist on handshake channels
  function automatic logic hs_only(input logic [AW-1:0] a);
    hs_only = (a == OFS_ARM) || (a == OFS_FLAG);
  endfunction

  qph_bus_t             state_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [31:0]          prdata_q;
  logic                 setup_ok;
  logic                 done;
  logic                 go;
  logic                 wr;
  logic                 rd;
  logic                 addr_err;
  logic                 mapped;
  logic [31:0]          rd_mux;

  logic [1:0]           sel_q;
  qph_dt_t              dt_q;
  logic [NCH-1:0][DW-1:0] dir_q;
  logic [NCH-1:0][DW-1:0] out_q;
  logic [NCH-1:0][DW-1:0] dir_p;
  logic [NCH-1:0][DW-1:0] out_p;
  logic [NHS-1:0][1:0]  arm_q;
  logic [NHS-1:0][1:0]  arm_p;
  logic [NHS-1:0]       pol_q;
  logic [NHS-1:0]       pol_p;
  logic                 pend_q;

  logic [NCH-1:0][DW-1:0] pin_s1_q;
  logic [NCH-1:0][DW-1:0] pin_s2_q;

  logic                 restore;
  logic                 hsclr;
  logic                 fire;
  logic                 apply;
  logic                 immediate;
  logic                 set_wr;

  logic [NHS-1:0]       ev;
  logic [NHS-1:0]       flag_q;
  logic [NHS-1:0]       flag_clr;
  logic                 flag_rd;
  logic                 sel_hs;
  logic                 sel_ev;
  logic [1:0]           sel_act;
  logic                 srq_q;
  logic                 wait_satisfier_q;
  logic [DW-1:0]        err_q;

  logic                 csel_d_q;
  logic                 csel_rise;
  logic [22:0]          act_cnt_q;
  logic                 act_q;

  logic                 flt_s1_q;
  logic                 flt_s2_q;
  logic [1:0]           boot_q;
  logic                 fault_q;

  // ---------------- APB slave: one wait state, answer from flops ----------
  assign setup_ok = psel & penable;
  assign done     = (state_q == BUS_RESP) & setup_ok;
  assign go       = done & card_selected & ~pslverr_q;
  assign wr       = go & pwrite;
  assign rd       = go & ~pwrite;

  assign mapped   = (paddr == OFS_CTRL) || (paddr == OFS_CMD) ||
                    (paddr == OFS_DIR) || (paddr == OFS_OUTVAL) ||
                    (paddr == OFS_PINS) || (paddr == OFS_ARM) ||
                    (paddr == OFS_FLAG) || (paddr == OFS_STATUS);
  assign addr_err = ~mapped | (hs_only(paddr) & (sel_q == SEL_CH1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BUS_IDLE;
    end else if (ce) begin
      unique case (state_q)
        BUS_IDLE: begin
          if (setup_ok) begin
            state_q <= BUS_RESP;
          end
        end
        BUS_RESP: begin
          state_q <= BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    sel_hs = (sel_q != SEL_CH1);
    if (!card_selected) begin
      rd_mux = 32'h0000_0000;
    end else if (paddr == OFS_CTRL) begin
      rd_mux[CTRL_SEL_LSB +: 2] = sel_q;
      rd_mux[CTRL_DT_LSB +: 2]  = dt_q;
    end else if (paddr == OFS_DIR) begin
      rd_mux[DW-1:0] = dir_q[sel_q];
    end else if (paddr == OFS_OUTVAL) begin
      rd_mux[DW-1:0] = out_q[sel_q];
    end else if (paddr == OFS_PINS) begin
      rd_mux[DW-1:0] = pin_s2_q[sel_q];
    end else if (paddr == OFS_ARM && sel_hs) begin
      rd_mux[ARM_ACT_LSB +: 2] = arm_q[hs_idx(sel_q)];
      rd_mux[ARM_POL_BIT]      = pol_q[hs_idx(sel_q)];
    end else if (paddr == OFS_FLAG && sel_hs) begin
      rd_mux[0] = flag_q[hs_idx(sel_q)];
    end else if (paddr == OFS_STATUS) begin
      rd_mux[ST_SRQ]            = srq_q;
      rd_mux[ST_WAIT_SATISFIER]           = wait_satisfier_q;
      rd_mux[ST_FAULT]          = fault_q;
      rd_mux[ST_PEND]           = pend_q;
      rd_mux[ST_ERR_LSB +: DW]  = err_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= (state_q == BUS_IDLE) & setup_ok;
      if ((state_q == BUS_IDLE) & setup_ok) begin
        pslverr_q <= addr_err & card_selected;
        prdata_q  <= (pwrite | addr_err) ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr_q <= 1'h0;
      end
    end
  end

  // ---------------- commands and deferred trigger -------------------------
  assign restore   = wr & (paddr == OFS_CMD) & pwdata[CMD_RESTORE];
  assign hsclr     = wr & (paddr == OFS_CMD) & pwdata[CMD_HSCLR];
  assign fire      = wr & (paddr == OFS_CMD) & pwdata[CMD_FIRE];
  assign apply     = ((dt_q == DT_BUS) & bus_trigger) |
                     ((dt_q == DT_CMD) & fire);
  assign immediate = (dt_q == DT_OFF);
  assign set_wr    = wr & ((paddr == OFS_DIR) || (paddr == OFS_OUTVAL) ||
                           (paddr == OFS_ARM));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= SEL_CH1;
      dt_q  <= DT_OFF;
    end else if (ce) begin
      if (restore) begin
        sel_q <= SEL_CH1;
        dt_q  <= DT_OFF;
      end else if (wr && paddr == OFS_CTRL) begin
        sel_q <= pwdata[CTRL_SEL_LSB +: 2];
        dt_q  <= qph_dt_t'(pwdata[CTRL_DT_LSB +: 2]);
      end
    end
  end

  // pending copy always follows the writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_p <= {NCH{DIR_RESET}};
      out_p <= {NCH{OUT_RESET}};
      arm_p <= {NHS{ACTION_NONE}};
      pol_p <= {NHS{POL_NEG}};
    end else if (ce) begin
      if (restore) begin
        dir_p <= {NCH{DIR_RESET}};
        out_p <= {NCH{OUT_RESET}};
        arm_p <= {NHS{ACTION_NONE}};
        pol_p <= {NHS{POL_NEG}};
      end else if (wr) begin
        if (paddr == OFS_DIR) begin
          dir_p[sel_q] <= pwdata[DW-1:0];
        end
        if (paddr == OFS_OUTVAL) begin
          out_p[sel_q] <= pwdata[DW-1:0];
        end
        if (paddr == OFS_ARM) begin
          arm_p[hs_idx(sel_q)] <= pwdata[ARM_ACT_LSB +: 2];
          pol_p[hs_idx(sel_q)] <= pwdata[ARM_POL_BIT];
        end
      end
    end
  end

  // active settings drive the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= {NCH{DIR_RESET}};
      out_q <= {NCH{OUT_RESET}};
      arm_q <= {NHS{ACTION_NONE}};
      pol_q <= {NHS{POL_NEG}};
    end else if (ce) begin
      if (restore) begin
        dir_q <= {NCH{DIR_RESET}};
        out_q <= {NCH{OUT_RESET}};
        arm_q <= {NHS{ACTION_NONE}};
        pol_q <= {NHS{POL_NEG}};
      end else if (apply) begin
        dir_q <= dir_p;
        out_q <= out_p;
        arm_q <= arm_p;
        pol_q <= pol_p;
      end else if (wr && immediate) begin
        if (paddr == OFS_DIR) begin
          dir_q[sel_q] <= pwdata[DW-1:0];
        end
        if (paddr == OFS_OUTVAL) begin
          out_q[sel_q] <= pwdata[DW-1:0];
        end
        if (paddr == OFS_ARM) begin
          arm_q[hs_idx(sel_q)] <= pwdata[ARM_ACT_LSB +: 2];
          pol_q[hs_idx(sel_q)] <= pwdata[ARM_POL_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'h0;
    end else if (ce) begin
      if (restore || apply || immediate) begin
        pend_q <= 1'h0;
      end else if (set_wr) begin
        pend_q <= 1'h1;
      end
    end
  end

  assign pio_out = out_q;
  assign pio_oe  = dir_q;
  assign pending = pend_q;

  // ---------------- data line sense ---------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else if (ce) begin
      pin_s1_q <= pio_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ---------------- handshake channels 2 to 4 -----------------------------
  for (genvar g = 0; g < NHS; g++) begin : g_hs
    qph_hs_edge u_edge (
      .clk                 (clk),
      .rst_n               (rst_n),
      .ce                  (ce),
      .output_taken_strobe (output_taken_strobe[g]),
      .input_valid_strobe  (input_valid_strobe[g]),
      .pos_edge            (pol_q[g]),
      .rearm               (hsclr | restore),
      .evt                 (ev[g])
    );
  end

  assign flag_rd = rd & (paddr == OFS_FLAG);

  always_comb begin
    flag_clr = '0;
    if (flag_rd) begin
      flag_clr[hs_idx(sel_q)] = 1'h1;
    end
    if (hsclr || restore) begin
      flag_clr = '1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else if (ce) begin
      flag_q <= (ev & ~{NHS{hsclr | restore}}) |
                (flag_q & ~flag_clr);
    end
  end

  assign sel_ev  = (sel_q != SEL_CH1) & ev[hs_idx(sel_q)];
  assign sel_act = (sel_q != SEL_CH1) ? arm_q[hs_idx(sel_q)] : ACTION_NONE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srq_q  <= 1'h0;
      wait_satisfier_q <= 1'h0;
    end else if (ce) begin
      if (restore) begin
        srq_q  <= 1'h0;
        wait_satisfier_q <= 1'h0;
      end else begin
        srq_q  <= (sel_ev & sel_act[ACT_SRQ]) |
                  (srq_q & ~flag_rd);
        wait_satisfier_q <= (sel_ev & sel_act[ACT_WAIT_SATISFIER]) |
                  (wait_satisfier_q & ~flag_rd);
      end
    end
  end

  assign srq            = srq_q;
  assign wait_satisfier = wait_satisfier_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= ERR_NONE;
    end else if (ce) begin
      if (restore) begin
        err_q <= ERR_NONE;
      end else if (done && pslverr_q && mapped) begin
        err_q <= ERR_CH1;
      end
    end
  end

  // ---------------- activity indicator ------------------------------------
  assign csel_rise = card_selected & ~csel_d_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csel_d_q  <= 1'h0;
      act_cnt_q <= 23'h00_0000;
      act_q     <= 1'h0;
    end else if (ce) begin
      csel_d_q <= card_selected;
      if (csel_rise) begin
        act_cnt_q <= ACT_HOLD_CYCLES;
        act_q     <= 1'h1;
      end else if (act_cnt_q != 23'h00_0000) begin
        act_cnt_q <= act_cnt_q - 23'h00_0001;
        act_q     <= (act_cnt_q != 23'h00_0001);
      end else begin
        act_q <= 1'h0;
      end
    end
  end

  assign activity_led = act_q;

  // ---------------- self-test fault capture -------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_s1_q <= 1'h0;
      flt_s2_q <= 1'h0;
      boot_q   <= 2'h0;
      fault_q  <= 1'h0;
    end else if (ce) begin
      flt_s1_q <= self_test_fault;
      flt_s2_q <= flt_s1_q;
      if (boot_q != BOOT_DONE) begin
        boot_q <= boot_q + 2'h1;
      end
      if (boot_q == BOOT_SAMPLE) begin
        fault_q <= flt_s2_q;
      end
    end
  end

  assign error_led = fault_q;
  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;
endmodule
`default_nettype wire

// [tb/qph_io_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module qph_io_properties #(
  parameter logic [22:0] ACT_HOLD_CYCLES = qph_pkg::ACT_HOLD_CYC
) (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [qph_pkg::AW-1:0]       paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic [31:0]                  prdata,
  input wire logic                         pslverr,
  input wire logic [qph_pkg::NCH-1:0][qph_pkg::DW-1:0] pio_oe,
  input wire logic                         card_selected,
  input wire logic                         srq,
  input wire logic                         wait_satisfier,
  input wire logic                         activity_led
);
  import qph_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        sel_q;
  logic [22:0] hold_q;
  logic        rst_hit;
  logic        clr;
  assign rst_hit = pready && card_selected && pwrite && paddr == OFS_CMD
                   && pwdata[CMD_RESTORE];
  assign clr = rst_hit || (pready && card_selected && !pwrite
               && paddr == OFS_FLAG && !pslverr);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sel_q <= 1'b0;
    else sel_q <= card_selected;
  end
  // cycles since the latest selection, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold_q <= '0;
    else if (card_selected && !sel_q) hold_q <= '0;
    else if (hold_q != '1) hold_q <= hold_q + 23'h1;
  end
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_wait_state: assert property (s_setup |-> s_answer)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unsel_quiet: assert property (
    pready && !card_selected |-> !pslverr && prdata == 32'h0)
    else $error("unselected access answered");
  a_led_on: assert property ($rose(card_selected) |=> activity_led)
    else $error("activity led not lit on selection");
  a_led_hold: assert property (
    $fell(activity_led) |-> hold_q >= ACT_HOLD_CYCLES)
    else $error("activity led held too briefly");
  a_srq_stays: assert property (srq && !clr |=> srq)
    else $error("service request dropped early");
  a_wait_satisfier_stays: assert property (
    wait_satisfier && !clr |=> wait_satisfier)
    else $error("wait condition dropped early");
  a_restore_clr: assert property (rst_hit |=>
    pio_oe == '0 && !srq && !wait_satisfier)
    else $error("restore left state behind");
endmodule
`default_nettype wire

// [tb/qph_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module qph_far_end (
  input  wire logic                   clk,
  input  wire logic [qph_pkg::NCH-1:0][qph_pkg::DW-1:0] pio_out,
  input  wire logic [qph_pkg::NCH-1:0][qph_pkg::DW-1:0] pio_oe,
  input  wire logic [qph_pkg::DW-1:0] ext,
  output logic [qph_pkg::NCH-1:0][qph_pkg::DW-1:0]      pio_in,
  output logic [qph_pkg::NHS-1:0]     output_taken_strobe,
  output logic [qph_pkg::NHS-1:0]     input_valid_strobe
);
  import qph_pkg::*;
  // driven lines read back; others show what user logic puts on them
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pio_in[i] = (pio_out[i] & pio_oe[i]) | (ext & ~pio_oe[i]);
    end
  end
  initial begin
    output_taken_strobe = '1;
    input_valid_strobe = '1;
  end
  // each level is held six cycles, above the minimum strobe width
  task automatic set(input int c, input logic w, input logic l);
    @(posedge clk);
    if (w) input_valid_strobe[c] <= l;
    else output_taken_strobe[c] <= l;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [tb/quad_parallel_io_handshake_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module quad_parallel_io_handshake_tb_top;
  import qph_pkg::*;
  localparam logic [22:0] HOLD = 23'h14;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, bus_trigger = 1'b0, card_selected = 1'b0;
  logic self_test_fault = 1'b0, pready, pslverr, er, srq, wait_satisfier;
  logic activity_led, error_led, pending;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [NCH-1:0][DW-1:0] pio_in, pio_out, pio_oe, dir_m, out_m;
  logic [DW-1:0] ext = 8'hFF;
  logic [NHS-1:0] ots, ivs;
  int failures = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  qph_io_top #(.ACT_HOLD_CYCLES(HOLD)) DUT (.clk, .rst_n, .ce(1'b1),
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .pio_in, .pio_out, .pio_oe, .output_taken_strobe(ots),
    .input_valid_strobe(ivs), .bus_trigger, .card_selected,
    .self_test_fault, .srq, .wait_satisfier, .activity_led, .error_led,
    .pending);
  qph_far_end FAR (.clk, .pio_out, .pio_oe, .ext, .pio_in,
    .output_taken_strobe(ots), .input_valid_strobe(ivs));
  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d = 32'h0);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) `CHK(n, 0)
    @(posedge clk);
  endtask
  task automatic pulse_bus();
    bus_trigger <= 1'b1;
    @(posedge clk);
    bus_trigger <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic do_reset(input logic f);
    rst_n <= 1'b0;
    self_test_fault <= f;
    card_selected <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    card_selected <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [DW-1:0] pin_exp(input logic [DW-1:0] o, d, x);
    return (o & d) | (x & ~d);
  endfunction
  task automatic over(input string s);
    $display("test %s over", s);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // the whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    failures++;
    give_verdict();
  end
  initial begin
    int c;
    int a;
    logic p;
    logic w;
    logic [DW-1:0] d;
    logic [DW-1:0] o;
    void'($urandom(93));
    dir_m = '0;
    out_m = '0;
    do_reset(1'b0);
    `CHK(activity_led, 1'b1)
    `CHK(error_led, 1'b0)
    apb(1'b0, OFS_CTRL);
    `CHK(rd, 32'h0)
    `CHK(pio_oe, dir_m)
    apb(1'b0, OFS_PINS);
    `CHK(rd, 32'hFF)
    repeat (30) @(posedge clk);
    `CHK(activity_led, 1'b0)
    over("defaults");
    for (c = 0; c < NCH; c++) begin
      d = (c == 1) ? 8'hFF : (c == 2) ? 8'h00 : 8'($urandom);
      o = 8'($urandom);
      apb(1'b1, OFS_CTRL, 32'(c));
      apb(1'b1, OFS_DIR, 32'(d));
      apb(1'b1, OFS_OUTVAL, 32'(o));
      dir_m[c] = d;
      out_m[c] = o;
      `CHK(pio_oe, dir_m)
      `CHK(pio_out, out_m)
    end
    ext <= 8'($urandom);
    for (c = 0; c < NCH; c++) begin
      apb(1'b1, OFS_CTRL, 32'(c));
      apb(1'b0, OFS_PINS);
      `CHK(rd[7:0], pin_exp(out_m[c], dir_m[c], ext))
    end
    over("ports");
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_ARM, 32'h3);
    `CHK(er, 1'b1)
    apb(1'b0, OFS_FLAG);
    `CHK(er, 1'b1)
    apb(1'b0, OFS_STATUS);
    `CHK(rd[15:8], ERR_CH1)
    apb(1'b0, 8'h20);
    `CHK(er, 1'b1)
    card_selected <= 1'b0;
    apb(1'b1, OFS_DIR, 32'h5A);
    `CHK(pio_oe, dir_m)
    apb(1'b0, OFS_STATUS);
    `CHK(rd, 32'h0)
    card_selected <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(activity_led, 1'b1)
    over("refusals");
    for (c = 1; c < NCH; c++) begin
      for (a = 0; a < 4; a++) begin
        p = 1'($urandom);
        w = 1'($urandom);
        apb(1'b1, OFS_CTRL, 32'(c));
        apb(1'b1, OFS_ARM, 32'(a | (p << 2)));
        FAR.set(c - 1, w, 1'b0);
        `CHK(srq, a[1] & ~p)
        `CHK(wait_satisfier, a[0] & ~p)
        FAR.set(c - 1, w, 1'b1);
        `CHK(srq, a[1])
        `CHK(wait_satisfier, a[0])
        apb(1'b0, OFS_FLAG);
        `CHK(rd, 32'h1)
        `CHK(srq | wait_satisfier, 1'b0)
        apb(1'b0, OFS_FLAG);
        `CHK(rd, 32'h0)
      end
    end
    over("actions");
    d = 8'($urandom) | 8'h01;
    o = ~out_m[2];
    apb(1'b1, OFS_CTRL, 32'h6);
    apb(1'b1, OFS_DIR, 32'(d));
    `CHK(pio_oe, dir_m)
    `CHK(pending, 1'b1)
    pulse_bus();
    dir_m[2] = d;
    `CHK(pio_oe, dir_m)
    `CHK(pending, 1'b0)
    apb(1'b1, OFS_CTRL, 32'hA);
    apb(1'b1, OFS_OUTVAL, 32'(o));
    pulse_bus();
    `CHK(pio_out, out_m)
    apb(1'b1, OFS_CMD, 32'h4);
    out_m[2] = o;
    `CHK(pio_out, out_m)
    apb(1'b1, OFS_CTRL, 32'h2);
    apb(1'b1, OFS_OUTVAL, 32'h3C);
    `CHK(pending, 1'b0)
    pulse_bus();
    apb(1'b1, OFS_CMD, 32'h4);
    out_m[2] = 8'h3C;
    `CHK(pio_out, out_m)
    over("deferred");
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b1, OFS_ARM, 32'h3);
    FAR.set(2, 1'b0, 1'b0);
    FAR.set(2, 1'b0, 1'b1);
    apb(1'b1, OFS_CMD, 32'h2);
    `CHK(srq, 1'b1)
    `CHK(pio_oe, dir_m)
    apb(1'b0, OFS_FLAG);
    `CHK(rd, 32'h0)
    FAR.set(2, 1'b1, 1'b0);
    FAR.set(2, 1'b1, 1'b1);
    apb(1'b1, OFS_CMD, 32'h1);
    `CHK(srq | wait_satisfier, 1'b0)
    `CHK(pio_oe, '0)
    apb(1'b0, OFS_STATUS);
    `CHK(rd[15:8], ERR_NONE)
    apb(1'b1, OFS_CTRL, 32'h1);
    FAR.set(0, 1'b0, 1'b0);
    `CHK(srq | wait_satisfier, 1'b0)
    apb(1'b0, OFS_FLAG);
    `CHK(rd, 32'h1)
    FAR.set(0, 1'b0, 1'b1);
    over("restore");
    do_reset(1'b1);
    `CHK(error_led, 1'b1)
    apb(1'b0, OFS_STATUS);
    `CHK(rd[ST_FAULT], 1'b1)
    over("fault");
    give_verdict();
  end
endmodule
bind qph_io_top qph_io_properties #(.ACT_HOLD_CYCLES(ACT_HOLD_CYCLES)) u_prop (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
  .pslverr, .pio_oe, .card_selected, .srq, .wait_satisfier, .activity_led);
`default_nettype wire
